// file: rtl/acbs_pkg.sv
// Purpose: shared constants and types for the control byte sequencer
// Assumes: 50 MHz system clock
// Notes:   control byte layout, timing counts, state codes
`default_nettype none
package acbs_pkg;
	// ----------------------------------------------------------------
	// control byte field positions
	// ----------------------------------------------------------------
	localparam int POWER_MODE_HI_BIT = 7;
	localparam int POWER_MODE_LO_BIT = 6;
	localparam int SAMPLING_TIMING_BIT = 5;
	localparam int INPUT_CONFIG_BIT = 4;
	localparam int POLARITY_BIT = 3;
	localparam int CHANNEL_MSB = 2;
	localparam int CHANNEL_LSB = 0;
	localparam int RESULT_W = 10;

	// power mode codes
	localparam logic [1:0] PM_FULL_DOWN = 2'h0;
	localparam logic [1:0] PM_STANDBY = 2'h1;
	localparam logic [1:0] PM_RUN_INT_CLK = 2'h2;
	localparam logic [1:0] PM_RUN_EXT_CLK = 2'h3;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'hc0;
	localparam logic CLK_INT_RESET = 1'b0;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int ACQ_TIME_NS = 1000;
	localparam int CONV_TIME_NS = 3600;
	localparam int CONV_CYCLES = 13;
	localparam int ACQ_EXT_EDGES = 4;
	// internal acquisition length in system cycles (rounded down)
	localparam int ACQ_INT_CYC = (ACQ_TIME_NS * CLK_MHZ) / 1000;
	// internal conversion clock period in system cycles
	localparam int INT_DIV_CYC = (CONV_TIME_NS * CLK_MHZ) / (1000 * CONV_CYCLES);

	// one-hot sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACQ_INT = 4'h2,
		ST_ACQ_EXT = 4'h4,
		ST_CONV = 4'h8
	} acbs_state_e;

	// control byte as carried to the analog side
	typedef struct packed {
		logic power_mode_hi;
		logic power_mode_lo;
		logic sampling_timing_select;
		logic input_config_select;
		logic polarity_select;
		logic [2:0] channel_sel;
	} acbs_ctrl_s;

	// parallel bus pins after synchronisation
	typedef struct packed {
		logic conv_clk;
		logic upper_byte_select;
		logic rd_n;
		logic wr_n;
		logic cs_n;
		logic [7:0] data;
	} acbs_pins_s;
endpackage
`default_nettype wire

// file: rtl/acbs_top.sv
// Purpose: control byte decode and acquisition/conversion sequencing
// Assumes: bus pins and conversion clock pin are asynchronous to clk
// Notes:   analog core supplies the result word; this block times it
//
// Summary of operation
// - write with timing bit zero and a run code: timed acquisition
// - timed acquisition: four clocks or 1us
// - write with timing bit one: open acquisition
// - second write with timing bit zero ends open acquisition, converts
// - second write may change power bits
// - done flag low when result ready
// - done flag high on read or write
// - power-down codes keep last clock choice
// - both acquisition modes with either clock
// - external conversion clock after reset
// - power bits: down, standby, int, ext
// - bit five selects acquisition timing
// - bit four selects input configuration
// - bit three selects polarity
// - low three bits give channel
// - internal clock conversion about 3.4us
// - conversion lasts 13 conversion clocks
// - write during conversion restarts acquisition, or idles on a power-down code with timing bit zero
// - upper byte select chooses result byte
`timescale 1ns/1ps
`default_nettype none
module acbs_top
	import acbs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic upper_byte_select,
	input wire logic conv_clk,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic done_n,
	input wire logic [acbs_pkg::RESULT_W-1:0] core_result,
	output acbs_pkg::acbs_ctrl_s ctrl,
	output logic track,
	output logic converting,
	output logic conv_tick,
	output logic clk_internal,
	output logic standby,
	output logic power_down
);
	import acbs_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// power-down codes have the upper power bit clear
	function automatic logic is_power_down(input logic [1:0] pm);
		is_power_down = ~pm[1];
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	acbs_pins_s pin_meta_q;
	acbs_pins_s pin_sync_q;
	acbs_pins_s pin_prev_q;
	acbs_pins_s pin_raw;

	assign pin_raw = '{conv_clk: conv_clk, upper_byte_select: upper_byte_select,
		rd_n: rd_n, wr_n: wr_n, cs_n: cs_n, data: data_in};

	// two flops per pin, third stage only for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_q <= '{conv_clk: 1'b0, upper_byte_select: 1'b0, rd_n: 1'b1,
				wr_n: 1'b1, cs_n: 1'b1, data: 8'h00};
			pin_sync_q <= '{conv_clk: 1'b0, upper_byte_select: 1'b0, rd_n: 1'b1,
				wr_n: 1'b1, cs_n: 1'b1, data: 8'h00};
			pin_prev_q <= '{conv_clk: 1'b0, upper_byte_select: 1'b0, rd_n: 1'b1,
				wr_n: 1'b1, cs_n: 1'b1, data: 8'h00};
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	logic selected;
	logic wr_evt;
	logic rd_evt;
	logic ext_fall;

	// deselected device ignores clock, write and read
	assign selected = ~pin_sync_q.cs_n;
	// write event on rising strobe edge
	assign wr_evt = selected & pin_sync_q.wr_n & ~pin_prev_q.wr_n;
	// read cycle starts on falling strobe edge
	assign rd_evt = selected & ~pin_sync_q.rd_n & pin_prev_q.rd_n;
	// external conversion clock falling edge
	assign ext_fall = selected & ~pin_sync_q.conv_clk & pin_prev_q.conv_clk;

	// ----------------------------------------------------------------
	// internal conversion oscillator
	// ----------------------------------------------------------------
	localparam logic [4:0] DIV_LAST = 5'(INT_DIV_CYC - 1);
	acbs_state_e state_q;
	logic [4:0] div_q;
	logic [4:0] div_d;
	logic int_tick;

	// divider gives the internal conversion clock
	always_comb begin
		div_d = (div_q == DIV_LAST) ? 5'h00 : div_q + 5'h01;
		// held at zero outside conversion: no short first period
		if (state_q != ST_CONV) begin
			div_d = 5'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= 5'h00;
		end else begin
			div_q <= div_d;
		end
	end

	assign int_tick = (div_q == DIV_LAST);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	localparam logic [5:0] ACQ_INT_LAST = 6'(ACQ_INT_CYC - 1);
	localparam logic [5:0] ACQ_EXT_LAST = 6'(ACQ_EXT_EDGES - 1);
	localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);

	acbs_state_e state_d;
	acbs_ctrl_s ctrl_q;
	acbs_ctrl_s ctrl_d;
	logic clk_int_q;
	logic clk_int_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic done_n_q;
	logic done_n_d;
	logic [RESULT_W-1:0] result_q;
	logic [RESULT_W-1:0] result_d;
	logic tick;
	logic acq_step;
	acbs_ctrl_s wr_byte;
	logic [1:0] wr_pm;

	assign wr_byte = acbs_ctrl_s'(pin_sync_q.data);
	assign wr_pm = {wr_byte.power_mode_hi, wr_byte.power_mode_lo};
	// conversion clock follows the selected source
	assign tick = clk_int_q ? int_tick : ext_fall;
	// internal acquisition counts system cycles or clock edges
	assign acq_step = clk_int_q ? 1'b1 : ext_fall;

	// next-state decode of writes, acquisition and conversion
	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		clk_int_d = clk_int_q;
		cnt_d = cnt_q;
		done_n_d = done_n_q;
		result_d = result_q;
		if (rd_evt) begin
			done_n_d = 1'b1;
		end
		if (wr_evt) begin
			done_n_d = 1'b1;
			cnt_d = 6'h00;
			// run codes pick the clock, down codes keep it
			if (!is_power_down(wr_pm)) begin
				clk_int_d = (wr_pm == PM_RUN_INT_CLK);
			end
			if (state_q == ST_ACQ_EXT && !wr_byte.sampling_timing_select) begin
				// closing write: power bits may change, timing bit clears
				ctrl_d.power_mode_hi = wr_byte.power_mode_hi;
				ctrl_d.power_mode_lo = wr_byte.power_mode_lo;
				ctrl_d.sampling_timing_select = 1'b0;
				state_d = ST_CONV;
			end else begin
				ctrl_d = wr_byte;
				if (wr_byte.sampling_timing_select) begin
					state_d = ST_ACQ_EXT;
				end else if (is_power_down(wr_pm)) begin
					state_d = ST_IDLE;
				end else begin
					state_d = ST_ACQ_INT;
				end
			end
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_IDLE;
				end
				ST_ACQ_INT: begin
					if (acq_step) begin
						if (cnt_q == (clk_int_q ? ACQ_INT_LAST : ACQ_EXT_LAST)) begin
							cnt_d = 6'h00;
							state_d = ST_CONV;
						end else begin
							cnt_d = cnt_q + 6'h01;
						end
					end
				end
				ST_ACQ_EXT: begin
					state_d = ST_ACQ_EXT;
				end
				ST_CONV: begin
					if (tick) begin
						if (cnt_q == CONV_LAST) begin
							cnt_d = 6'h00;
							result_d = core_result;
							done_n_d = 1'b0;
							state_d = ST_IDLE;
						end else begin
							cnt_d = cnt_q + 6'h01;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					cnt_d = 6'h00;
				end
			endcase
		end
	end

	// sequencer registers; external clock after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			ctrl_q <= acbs_ctrl_s'(CTRL_RESET);
			clk_int_q <= CLK_INT_RESET;
			cnt_q <= 6'h00;
			done_n_q <= 1'b1;
			result_q <= RESULT_RESET;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			clk_int_q <= clk_int_d;
			cnt_q <= cnt_d;
			done_n_q <= done_n_d;
			result_q <= result_d;
		end
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	logic [7:0] hi_byte;
	logic [7:0] rd_d;
	logic [7:0] rd_q;
	logic oe_q;
	logic oe_d;

	assign hi_byte[1:0] = result_q[9:8];
	// upper lines zero in unipolar, sign copies in bipolar
	genvar gi;
	generate
		for (gi = 2; gi < 8; gi++) begin : g_fill
			assign hi_byte[gi] = ctrl_q.polarity_select ? 1'b0 : result_q[9];
		end
	endgenerate

	// byte choice every cycle, bus drive only while selected and reading
	always_comb begin
		rd_d = pin_sync_q.upper_byte_select ? hi_byte : result_q[7:0];
		oe_d = selected & ~pin_sync_q.rd_n;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			oe_q <= oe_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign data_out = rd_q;
	assign data_oe = oe_q;
	assign done_n = done_n_q;
	assign ctrl = ctrl_q;
	assign track = (state_q == ST_ACQ_INT) | (state_q == ST_ACQ_EXT);
	assign converting = (state_q == ST_CONV);
	assign conv_tick = (state_q == ST_CONV) & tick;
	assign clk_internal = clk_int_q;
	assign standby = ({ctrl_q.power_mode_hi, ctrl_q.power_mode_lo} == PM_STANDBY);
	assign power_down = ({ctrl_q.power_mode_hi, ctrl_q.power_mode_lo} == PM_FULL_DOWN);
endmodule // acbs_top
`default_nettype wire

// file: test/acbs_top_sva.sv
// Purpose: port checks for acbs_top
// Assumes: timed checks use the internal clock
// Notes: bound from the testbench
`timescale 1ns/1ps
`default_nettype none
module acbs_top_sva
	import acbs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic data_oe,
	input wire logic done_n,
	input wire acbs_pkg::acbs_ctrl_s ctrl,
	input wire logic track,
	input wire logic converting,
	input wire logic clk_internal,
	input wire logic standby,
	input wire logic power_down
);
	logic [7:0] acq_q, acq_d, cnv_q, cnv_d;
	// ------------------------------------------------
	// phase length counters
	// ------------------------------------------------
	always_comb begin
		acq_d = track ? acq_q + 8'h01 : 8'h00;
		cnv_d = converting ? cnv_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acq_q <= 8'h00;
			cnv_q <= 8'h00;
		end else begin
			acq_q <= acq_d;
			cnv_q <= cnv_d;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	property p_acq;
		$fell(track) && converting && clk_internal && !$past(ctrl.sampling_timing_select)
			|-> acq_q == 8'h32;
	endproperty
	a_acq: assert property (p_acq) else $error("acq length");
	property p_cnv;
		$fell(done_n) && clk_internal |-> cnv_q == 8'ha9;
	endproperty
	a_cnv: assert property (p_cnv) else $error("conv length");
	property p_done;
		$fell(done_n) |-> $fell(converting);
	endproperty
	a_done: assert property (p_done) else $error("done cause");
	property p_chain;
		$rose(converting) |-> $fell(track);
	endproperty
	a_chain: assert property (p_chain) else $error("acq to conv");
	property p_clr;
		$rose(track) |-> done_n;
	endproperty
	a_clr: assert property (p_clr) else $error("done not cleared");
	property p_oe;
		cs_n [*4] |-> !data_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven");
	property p_pm;
		{standby, power_down} == {!ctrl.power_mode_hi && ctrl.power_mode_lo,
			!ctrl.power_mode_hi && !ctrl.power_mode_lo};
	endproperty
	a_pm: assert property (p_pm) else $error("power decode");
	property p_keep;
		$changed(clk_internal) |-> ctrl.power_mode_hi && (clk_internal != ctrl.power_mode_lo);
	endproperty
	a_keep: assert property (p_keep) else $error("clock choice");
	property p_idle;
		!ctrl.power_mode_hi && !ctrl.sampling_timing_select |-> !track;
	endproperty
	a_idle: assert property (p_idle) else $error("acq in power-down");
	c_done: cover property ($fell(done_n));
	c_ext: cover property ($rose(track) && ctrl.sampling_timing_select);
	c_oe: cover property ($rose(data_oe));
endmodule // acbs_top_sva
`default_nettype wire

// file: test/acbs_host.sv
// Purpose: host processor model on the byte bus
// Assumes: strobes held four clocks high, write strobe four and read strobe five low
// Notes: conversion clock runs only on request, else held low
`timescale 1ns/1ps
`default_nettype none
module acbs_host (
	input wire logic clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic upper_byte_select,
	output logic conv_clk,
	output logic [7:0] data_in
);
	logic [7:0] drv;
	logic clk_run = 1'b0;
	int ph = 0;
	// bus level: device when enabled, else host
	assign data_in = data_oe ? data_out : drv;
	// conversion clock, eight clocks a period, low when stopped
	always @(posedge clk) begin
		#1;
		ph = clk_run ? (ph + 1) % 8 : 0;
		conv_clk = clk_run && (ph >= 4);
	end
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		upper_byte_select = 1'b0;
		drv = 8'h00;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// write, byte held around the rising strobe
	task automatic wr(input logic [7:0] b);
		idle(1);
		drv = b;
		cs_n = 1'b0;
		idle(4);
		wr_n = 1'b0;
		idle(4);
		wr_n = 1'b1;
		idle(4);
		cs_n = 1'b1;
		drv = ~b;
	endtask
	// read, data taken while strobe low
	task automatic rd(input logic hb, output logic [7:0] q);
		idle(1);
		upper_byte_select = hb;
		cs_n = 1'b0;
		rd_n = 1'b0;
		idle(5);
		// undriven bus reads as the inverse
		q = data_oe ? data_out : ~data_out;
		rd_n = 1'b1;
		idle(4);
		cs_n = 1'b1;
	endtask
	// select the device and run its conversion clock, or stop both
	task automatic run_sel(input logic on);
		idle(1);
		cs_n = ~on;
		clk_run = on;
	endtask
endmodule // acbs_host
`default_nettype wire

// file: test/test_acbs_top.sv
// Purpose: self-checking bench for acbs_top
// Assumes: host model drives the byte bus
// Notes: table rows then hand tests
`timescale 1ns/1ps
`default_nettype none
module test_acbs_top;
	import acbs_pkg::*;
	typedef struct packed {logic [7:0] b; logic [3:0] e;} acbs_row_s;
	logic clk, resetn, cs_n, wr_n, rd_n, upper_byte_select, conv_clk, data_oe, done_n;
	logic track, converting, clk_internal, standby, power_down;
	logic [7:0] data_in, data_out, q;
	logic conv_tick;
	logic [9:0] core_result;
	acbs_ctrl_s ctrl;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int ticks = 0;
	// byte, then {clk_internal, standby, power_down, done}
	acbs_row_s rows [6] = '{'{8'h9d, 4'h9}, '{8'h95, 4'h9}, '{8'h1a, 4'ha},
		'{8'h5a, 4'hc}, '{8'hd9, 4'h0}, '{8'h1a, 4'h2}};
	acbs_top DUT (.clk(clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.upper_byte_select(upper_byte_select), .conv_clk(conv_clk), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .done_n(done_n), .core_result(core_result),
		.ctrl(ctrl), .track(track), .converting(converting), .conv_tick(conv_tick),
		.clk_internal(clk_internal), .standby(standby), .power_down(power_down));
	acbs_host host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .upper_byte_select(upper_byte_select),
		.conv_clk(conv_clk), .data_in(data_in));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for the done flag
	task automatic wait_done(input logic want);
		int n;
		n = 0;
		while (done_n !== 1'b0 && n < 400) begin
			host.idle(1);
			n++;
		end
		chk(8'(done_n), {7'h00, ~want});
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// conversion clock steps seen
	always @(posedge clk) begin
		if (conv_tick === 1'b1)
			ticks++;
	end
	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		resetn = 1'b0;
		core_result = 10'h000;
		repeat (4) @(posedge clk);
		#1 resetn = 1'b1;
		host.idle(2);
		chk(ctrl, CTRL_RESET);
		chk(8'({clk_internal, done_n}), 8'h01);
		for (int i = 0; i < 6; i++) begin
			core_result = {~rows[i].b[1:0], ~rows[i].b};
			host.wr(rows[i].b);
			chk(ctrl, rows[i].b);
			chk(8'({clk_internal, standby, power_down}), 8'(rows[i].e[3:1]));
			wait_done(rows[i].e[0]);
			if (rows[i].e[0]) begin
				host.rd(1'b0, q);
				chk(q, ~rows[i].b);
				chk(8'(done_n), 8'h01);
				host.rd(1'b1, q);
				chk(q, {{6{~rows[i].b[1] & ~rows[i].b[3]}}, ~rows[i].b[1:0]});
			end
		end
		// open acquisition, close with new power bits
		host.wr(8'hf5);
		host.idle(100);
		chk(8'({track, converting}), 8'h02);
		host.wr(8'h95);
		ticks = 0;
		chk(8'({track, converting}), 8'h01);
		chk(ctrl, 8'h95);
		chk(8'(clk_internal), 8'h01);
		wait_done(1'b1);
		chk(8'(ticks), 8'h0d);
		// rewrite during conversion
		host.wr(8'h9d);
		host.idle(60);
		chk(8'(converting), 8'h01);
		host.wr(8'h9d);
		chk(8'({track, converting, done_n}), 8'h05);
		wait_done(1'b1);
		// external clock, timed acquisition, clock runs while selected
		host.wr(8'hd9);
		chk(8'(clk_internal), 8'h00);
		host.run_sel(1'b1);
		ticks = 0;
		wait_done(1'b1);
		chk(8'(ticks), 8'h0d);
		host.run_sel(1'b0);
		// external clock, open acquisition closed by second write
		host.wr(8'he9);
		host.wr(8'hc9);
		chk(8'({track, converting}), 8'h01);
		host.run_sel(1'b1);
		ticks = 0;
		wait_done(1'b1);
		chk(8'(ticks), 8'h0d);
		host.run_sel(1'b0);
		// reset in mid conversion, then a fresh conversion
		host.wr(8'h9d);
		host.idle(80);
		chk(8'(converting), 8'h01);
		resetn = 1'b0;
		host.idle(2);
		chk(ctrl, CTRL_RESET);
		chk(8'({track, converting, clk_internal, done_n}), 8'h01);
		host.idle(2);
		resetn = 1'b1;
		host.idle(2);
		chk(8'({track, converting, clk_internal, done_n}), 8'h01);
		host.wr(8'h9d);
		wait_done(1'b1);
		wrap_up();
	end
endmodule // test_acbs_top
bind acbs_top acbs_top_sva u_sva (.clk(clk), .resetn(resetn), .cs_n(cs_n),
	.data_oe(data_oe), .done_n(done_n), .ctrl(ctrl), .track(track),
	.converting(converting), .clk_internal(clk_internal), .standby(standby),
	.power_down(power_down));
`default_nettype wire
